//--- core/out_switch_top.sv
// Two-switch contact output block with AHB-Lite configuration registers
//
// Functional notes
// - Selector 0 holds the active state always; closed at polarity 0, open at polarity 1
// - Selector 2 latches on reset until cleared
// - Selector 3 follows position error until recovered
// - Selector 4 tight shutoff enabled and below
// - Selector 5 position strictly below low limit
// - Selector 6 position strictly above high limit
// - Selector 7 follows manual mode flag
// - Two identical switches, configured independently except for the shared tight shutoff threshold
// - Open unpowered; polarity chosen after boot
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module out_switch_top
    import out_switch_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic [POS_W-1:0] position,
    input  wire logic             failsafe,
    input  wire logic             reset_event,
    input  wire logic             pos_error,
    input  wire logic             tso_enable,
    input  wire logic             manual,
    input  wire logic             boot_done,
    output logic [NUM_SW-1:0]     contact_closed
);
    logic [SEL_W-1:0] sel_q [NUM_SW];
    logic             pol_q [NUM_SW];
    logic [POS_W-1:0] low_q [NUM_SW];
    logic [POS_W-1:0] high_q [NUM_SW];
    logic [POS_W-1:0] tso_q;
    logic             wr_pend_q;
    logic [2:0]       wr_idx_q;
    logic [31:0]      rdata_q;
    logic [NUM_SW-1:0] act;
    logic [NUM_SW-1:0] latched;
    logic             addr_ok;
    logic             rd_go;
    logic [2:0]       aidx;
    logic [31:0]      rd_mux;
    logic [NUM_SW-1:0] clr_sw;

    function automatic logic [2:0] word_idx(input logic [31:0] a);
        return a[WIDX_HI:WIDX_LO];
    endfunction : word_idx

    function automatic logic [31:0] pack_ctrl(input logic [SEL_W-1:0] s,
                                              input logic p);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_SEL_LSB +: SEL_W] = s;
        w[CTRL_POL_BIT] = p;
        return w;
    endfunction : pack_ctrl

    // Registers react only to valid transfers that the bus lets through
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_go = addr_ok && !hwrite;
    assign aidx = word_idx(haddr);

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (aidx)
            word_idx(ADDR_CTRL0): rd_mux = pack_ctrl(sel_q[0], pol_q[0]);
            word_idx(ADDR_CTRL1): rd_mux = pack_ctrl(sel_q[1], pol_q[1]);
            word_idx(ADDR_LIM0):  rd_mux = {high_q[0], low_q[0]};
            word_idx(ADDR_LIM1):  rd_mux = {high_q[1], low_q[1]};
            word_idx(ADDR_TSO):   rd_mux = {16'h0000, tso_q};
            word_idx(ADDR_STAT): begin
                rd_mux[STAT_RST_BIT +: NUM_SW] = latched;
                rd_mux[STAT_SW_LSB +: NUM_SW] = contact_closed;
                rd_mux[STAT_BOOT_BIT] = boot_done;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 3'h0;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_idx_q <= aidx;
            rdata_q <= rd_go ? rd_mux : rdata_q;
        end
    end

    // Status clear: writing ones to the status word drops the latches
    always_comb begin
        clr_sw = '0;
        if (wr_pend_q && wr_idx_q == word_idx(ADDR_STAT)) begin
            clr_sw = hwdata[STAT_RST_BIT +: NUM_SW];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_SW; i++) begin
                sel_q[i] <= SEL_RESET_VAL;
                pol_q[i] <= POL_RESET_VAL;
                low_q[i] <= LOW_RESET_VAL;
                high_q[i] <= HIGH_RESET_VAL;
            end
            tso_q <= TSO_RESET_VAL;
        end else if (wr_pend_q) begin
            unique case (wr_idx_q)
                word_idx(ADDR_CTRL0): begin
                    sel_q[0] <= hwdata[CTRL_SEL_LSB +: SEL_W];
                    pol_q[0] <= hwdata[CTRL_POL_BIT];
                end
                word_idx(ADDR_CTRL1): begin
                    sel_q[1] <= hwdata[CTRL_SEL_LSB +: SEL_W];
                    pol_q[1] <= hwdata[CTRL_POL_BIT];
                end
                // limit ordering is left to software
                word_idx(ADDR_LIM0): begin
                    low_q[0] <= hwdata[LIM_LOW_LSB +: POS_W];
                    high_q[0] <= hwdata[LIM_HIGH_LSB +: POS_W];
                end
                // no hardware check against full open
                word_idx(ADDR_LIM1): begin
                    low_q[1] <= hwdata[LIM_LOW_LSB +: POS_W];
                    high_q[1] <= hwdata[LIM_HIGH_LSB +: POS_W];
                end
                word_idx(ADDR_TSO): tso_q <= hwdata[LIM_LOW_LSB +: POS_W];
                default: ;
            endcase
        end
    end

    // two identical cells, each with its own selector, polarity and limits; tso_q is shared
    for (genvar g = 0; g < NUM_SW; g++) begin : g_sw
        switch_cell u_cell (
            .hclk           (hclk),
            .hresetn        (hresetn),
            .sel            (sel_q[g]),
            .pol_open       (pol_q[g]),
            .low_lim        (low_q[g]),
            .high_lim       (high_q[g]),
            .tso_thr        (tso_q),
            .position       (position),
            .failsafe       (failsafe),
            .reset_event    (reset_event),
            .status_clear   (clr_sw[g]),
            .pos_error      (pos_error),
            .tso_enable     (tso_enable),
            .manual         (manual),
            .boot_done      (boot_done),
            .active         (act[g]),
            .rst_latched    (latched[g]),
            .contact_closed (contact_closed[g])
        );
    end

    // a write to switch 0's control never moves switch 1's selector
    chk_sel_indep: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (wr_pend_q && wr_idx_q == word_idx(ADDR_CTRL0))
        |=> $stable(sel_q[1]))
        else $error("switch 1 selector changed on switch 0 write");
    // open during boot regardless of condition
    chk_unbooted_open: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!boot_done ##1 !boot_done) |-> contact_closed == '0)
        else $error("contact closed before boot");
    chk_rd_ready: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd_go |=> (hrdata == $past(rd_mux)))
        else $error("read data not returned next cycle");

    cov_write_ctrl: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_idx_q == word_idx(ADDR_CTRL1));
    cov_both_closed: cover property (@(posedge hclk) disable iff (!hresetn)
        contact_closed == '1 && act != '0);
endmodule : out_switch_top
`default_nettype wire

//--- core/out_switch_pkg.sv
// Constants and types for the output switch condition selector
package out_switch_pkg;
    localparam int POS_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_SW = 2;
    localparam logic [31:0] ADDR_CTRL0 = 32'h0000_0000;
    localparam logic [31:0] ADDR_CTRL1 = 32'h0000_0004;
    localparam logic [31:0] ADDR_LIM0 = 32'h0000_0008;
    localparam logic [31:0] ADDR_LIM1 = 32'h0000_000c;
    localparam logic [31:0] ADDR_TSO = 32'h0000_0010;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0014;
    localparam int WIDX_HI = 4;
    localparam int WIDX_LO = 2;
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_POL_BIT = 4;
    localparam int LIM_LOW_LSB = 0;
    localparam int LIM_HIGH_LSB = 16;
    localparam int STAT_RST_BIT = 0;
    localparam int STAT_SW_LSB = 4;
    localparam int STAT_BOOT_BIT = 8;
    localparam logic [SEL_W-1:0] SEL_RESET_VAL = 3'h0;
    localparam logic POL_RESET_VAL = 1'b0;
    localparam logic [POS_W-1:0] LOW_RESET_VAL = 16'h0000;
    localparam logic [POS_W-1:0] HIGH_RESET_VAL = 16'hffff;
    localparam logic [POS_W-1:0] TSO_RESET_VAL = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [SEL_W-1:0] {
        COND_NORMAL,
        COND_FAILSAFE,
        COND_RESET,
        COND_POS_ERR,
        COND_TIGHT,
        COND_LOW_LIM,
        COND_HIGH_LIM,
        COND_MANUAL
    } cond_type;
endpackage : out_switch_pkg

//--- core/switch_cell.sv
// One output switch: condition multiplexer, reset latch and contact drive
`timescale 1ns/1ps
`default_nettype none
module switch_cell
    import out_switch_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic             pol_open,
    input  wire logic [POS_W-1:0] low_lim,
    input  wire logic [POS_W-1:0] high_lim,
    input  wire logic [POS_W-1:0] tso_thr,
    input  wire logic [POS_W-1:0] position,
    input  wire logic             failsafe,
    input  wire logic             reset_event,
    input  wire logic             status_clear,
    input  wire logic             pos_error,
    input  wire logic             tso_enable,
    input  wire logic             manual,
    input  wire logic             boot_done,
    output logic                  active,
    output logic                  rst_latched,
    output logic                  contact_closed
);
    logic rst_latch_q;
    logic rst_latch_d;
    logic cond;
    logic drive_q;
    logic drive_d;
    cond_type mode;

    assign mode = cond_type'(sel);

    // latch, a new event wins over a clear
    assign rst_latch_d = reset_event | (rst_latch_q & ~status_clear);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_latch_q <= 1'b0;
        end else begin
            rst_latch_q <= rst_latch_d;
        end
    end

    always_comb begin
        cond = 1'b0;
        unique case (mode)
            // never switches, always active: closed at polarity 0, open at polarity 1
            COND_NORMAL:   cond = 1'b1;
            COND_FAILSAFE: cond = failsafe;
            COND_RESET:    cond = rst_latch_q;
            COND_POS_ERR:  cond = pos_error;
            COND_TIGHT:    cond = tso_enable && (position < tso_thr);
            COND_LOW_LIM:  cond = position < low_lim;
            COND_HIGH_LIM: cond = position > high_lim;
            COND_MANUAL:   cond = manual;
        endcase
    end

    // polarity selects closed or open when active
    assign drive_d = boot_done ? (cond ^ pol_open) : 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign contact_closed = drive_q;
    assign active = cond;
    assign rst_latched = rst_latch_q;

    chk_normal_closed: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_NORMAL && boot_done && !pol_open) |=> drive_q)
        else $error("normal selector did not close the contact");
    chk_latch_holds: assert property (
        @(posedge hclk) disable iff (!hresetn)
        reset_event |=> rst_latch_q)
        else $error("reset event not latched");
    chk_latch_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (rst_latch_q && !status_clear && !reset_event) |=> rst_latch_q)
        else $error("reset latch dropped without clear");
    chk_low_limit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_LOW_LIM && boot_done && position < low_lim)
        |=> (drive_q == !$past(pol_open)))
        else $error("low limit did not drive contact");
    chk_high_limit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_HIGH_LIM && boot_done && position <= high_lim)
        |=> (drive_q == $past(pol_open)))
        else $error("high limit active at or below threshold");
    chk_boot_open: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !boot_done |=> !drive_q)
        else $error("contact closed before boot");
    chk_tight_off: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_TIGHT && !tso_enable && boot_done)
        |=> (drive_q == $past(pol_open)))
        else $error("tight shutoff active while disabled");
    chk_manual_mode: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_MANUAL && boot_done)
        |=> (drive_q == ($past(manual) ^ $past(pol_open))))
        else $error("manual condition mismatch");
    chk_fail_safe: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_FAILSAFE && boot_done)
        |=> (drive_q == ($past(failsafe) ^ $past(pol_open))))
        else $error("failsafe condition mismatch");
    chk_pos_err: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (mode == COND_POS_ERR && boot_done)
        |=> (drive_q == ($past(pos_error) ^ $past(pol_open))))
        else $error("position error condition mismatch");

    cov_latch_clear: cover property (@(posedge hclk) disable iff (!hresetn)
        rst_latch_q ##1 status_clear ##1 !rst_latch_q);
    cov_low_trip: cover property (@(posedge hclk) disable iff (!hresetn)
        mode == COND_LOW_LIM && cond && boot_done);
    cov_high_trip: cover property (@(posedge hclk) disable iff (!hresetn)
        mode == COND_HIGH_LIM && cond && boot_done);
endmodule : switch_cell
`default_nettype wire

//--- tb/dc_load.sv
// Behavioural model of the external DC load on each contact output
`timescale 1ns/1ps
`default_nettype none
module dc_load
    import out_switch_pkg::*;
(
    input  wire logic [NUM_SW-1:0] contact_closed,
    output logic [NUM_SW-1:0]      load_on
);
    // open contact carries no load current
    // Leakage through an open contact is too small to light the load
    assign load_on = contact_closed;
endmodule : dc_load
`default_nettype wire

//--- tb/output_switch_condition_selector_bench.sv
// Bench for the two-switch contact output block
`timescale 1ns/1ps
`default_nettype none
module output_switch_condition_selector_bench
    import out_switch_pkg::*;
;
    logic              hclk, hresetn, hsel, hwrite, hready;
    logic [31:0]       haddr, hwdata, hrdata, rd;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic              hreadyout, hresp;
    logic [POS_W-1:0]  position;
    logic              failsafe, reset_event, pos_error;
    logic              tso_enable, manual, boot_done;
    logic [NUM_SW-1:0] contact_closed, load_on;
    logic [POS_W-1:0]  low_lim [2];
    logic [POS_W-1:0]  high_lim [2];
    logic [POS_W-1:0]  pos_tab [4];
    int                err_count, check_count, cycles;

    assign hready = hreadyout;

    out_switch_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .position(position),
        .failsafe(failsafe), .reset_event(reset_event),
        .pos_error(pos_error), .tso_enable(tso_enable), .manual(manual),
        .boot_done(boot_done), .contact_closed(contact_closed));

    dc_load u_load (.contact_closed(contact_closed), .load_on(load_on));

    task stop_test;
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    // Inputs held for three edges, so the contact is steady at the third
    task settle;
        repeat (3) @(posedge hclk);
    endtask : settle

    function logic cond(input logic [2:0] s, input int i);
        case (s)
            3'h0: return 1'b1;
            3'h1: return failsafe;
            3'h3: return pos_error;
            3'h4: return tso_enable && (position < 16'h0080);
            3'h5: return position < low_lim[i];
            3'h6: return position > high_lim[i];
            3'h7: return manual;
            default: return 1'b0;
        endcase
    endfunction : cond

    task check_sw(input logic [2:0] s0, input logic [2:0] s1);
        chk({30'h0, load_on}, {30'h0, cond(s1, 1) ^ 1'b1, cond(s0, 0)});
    endtask : check_sw

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            stop_test;
        end
    end

    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {failsafe, reset_event, pos_error, tso_enable, manual} = '0;
        boot_done = 1'b0;
        position = 16'h0000;
        hresetn = 1'b0;
        low_lim = '{16'h0100, 16'h0200};
        high_lim = '{16'h0800, 16'h0400};
        pos_tab = '{16'h0040, 16'h0100, 16'h0800, 16'h0801};
        repeat (8) @(posedge hclk);
        chk({30'h0, contact_closed}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, ADDR_LIM0, 32'h0);
        chk(rd, {HIGH_RESET_VAL, LOW_RESET_VAL});
        chk({30'h0, hresp, hreadyout}, 32'h1);
        bus(1'b0, 32'h0000_0018, 32'h0);
        chk(rd, 32'h0);
        settle;
        chk({30'h0, load_on}, 32'h0);
        boot_done <= 1'b1;
        settle;
        chk({30'h0, load_on}, 32'h3);
        position <= 16'hffff;
        settle;
        chk({30'h0, load_on}, 32'h3);
        // Low limits above the shutoff threshold, high limits below full
        bus(1'b1, ADDR_LIM0, {high_lim[0], low_lim[0]});
        bus(1'b1, ADDR_LIM1, {high_lim[1], low_lim[1]});
        bus(1'b1, ADDR_TSO, 32'h0000_0080);
        bus(1'b0, ADDR_LIM1, 32'h0);
        chk(rd, {high_lim[1], low_lim[1]});
        for (int s = 1; s < 8; s++) begin
            bus(1'b1, ADDR_CTRL0, 32'(s));
            bus(1'b1, ADDR_CTRL1, 32'h10 | 32'((s + 3) % 8));
            for (int v = 0; v < 4; v++) begin
                position <= pos_tab[v];
                failsafe <= v[0];
                pos_error <= v[1];
                tso_enable <= (v != 1);
                manual <= v[0] ^ v[1];
                settle;
                check_sw(3'(s), 3'((s + 3) % 8));
            end
        end
        bus(1'b1, ADDR_CTRL0, 32'h2);
        bus(1'b1, ADDR_CTRL1, 32'h2);
        settle;
        chk({30'h0, load_on}, 32'h0);
        reset_event <= 1'b1;
        @(posedge hclk);
        reset_event <= 1'b0;
        settle;
        chk({30'h0, load_on}, 32'h3);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_0133);
        bus(1'b1, ADDR_STAT, 32'h1);
        settle;
        chk({30'h0, load_on}, 32'h2);
        bus(1'b1, ADDR_STAT, 32'h2);
        settle;
        chk({30'h0, load_on}, 32'h0);
        bus(1'b1, ADDR_CTRL0, 32'h0);
        boot_done <= 1'b0;
        settle;
        chk({30'h0, load_on}, 32'h0);
        boot_done <= 1'b1;
        hresetn <= 1'b0;
        @(posedge hclk);
        chk({30'h0, contact_closed}, 32'h0);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, ADDR_CTRL1, 32'h0);
        chk(rd, 32'h0);
        settle;
        chk({30'h0, load_on}, 32'h3);
        stop_test;
    end
endmodule : output_switch_condition_selector_bench
`default_nettype wire
